// *** rtl/storage_key_protection.sv ***
`timescale 1ns/1ns
`default_nettype none

module storage_key_protection (
    input  wire logic                                      clk,
    input  wire logic                                      reset,
    input  wire logic [storage_key_pkg::BUS_ADDR_W-1:0]    avsAddress,
    input  wire logic                                      avsRead,
    input  wire logic                                      avsWrite,
    input  wire logic [3:0]                                avsByteEnable,
    input  wire logic [storage_key_pkg::DATA_W-1:0]        avsWriteData,
    output logic      [storage_key_pkg::DATA_W-1:0]        avsReadData,
    output logic                                           avsWaitRequest,
    input  wire logic                                      storeRequest,
    input  wire logic [storage_key_pkg::MEM_ADDR_W-1:0]    storeAddress,
    input  wire storage_key_pkg::mode_t                    mode,
    input  wire logic [2:0]                                selectorIndex,
    input  wire logic                                      privilegedState,
    input  wire logic                                      stateEnter,
    input  wire logic [1:0]                                stateIndex,
    input  wire logic                                      consoleKeyLoad,
    input  wire logic [storage_key_pkg::KEY_W-1:0]         consoleKey,
    input  wire logic                                      channelKeyLoad,
    input  wire logic [2:0]                                channelKeyIndex,
    input  wire logic [storage_key_pkg::KEY_W-1:0]         channelKey,
    output logic                                           memoryWriteStrobe,
    output logic                                           keyErrorSignal,
    output logic                                           keyMatchOk,
    output logic                                           addressExceptionFlag,
    output logic                                           protectionCheckFlag,
    output logic                                           interruptRequest
);
    import storage_key_pkg::*;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SET_KEY_CHECK,
        SEQ_KEY_TRANSFER,
        SEQ_KEY_MERGE_WRITE,
        SEQ_KEY_READ,
        SEQ_INSERT_TRANSFER
    } seq_t;

    typedef struct packed {
        seq_t                                    seq;
        logic                                    waitReq;
        logic [DATA_W-1:0]                       readData;
        logic [STATUS_W-1:0]                     status;
        logic [STATUS_W-1:0]                     intEnable;
        logic                                    irq;
        logic [DATA_W-1:0]                       opAddr;
        logic [DATA_W-1:0]                       opKey;
        logic [DATA_W-1:0]                       result;
        logic [PROGRAM_STATES-1:0][DATA_W-1:0]   isw;
        logic [KEY_W-1:0]                        normalKey;
        logic [CHAN_KEYS-1:0][KEY_W-1:0]         chanKey;
        logic [PROT_ADDR_W-1:0]                  protectAddressReg;
        logic                                    halfSelectFlag;
        logic [KEY_WORD_W-1:0]                   dataRegister;
        logic [KEY_W-1:0]                        conditionFlipFlops;
        logic [KEYMEM_WORDS-1:0][KEY_WORD_W:0]   keyMem;
        logic                                    writeStrobe;
        logic                                    keyError;
        logic                                    matchOk;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] oldValue,
                                                     input logic [DATA_W-1:0] newValue,
                                                     input logic [3:0]        enables);
        logic [DATA_W-1:0] merged;
        merged = oldValue;
        for (int b = 0; b < 4; b++) begin
            if (enables[b]) begin
                merged[b*8 +: 8] = newValue[b*8 +: 8];
            end
        end
        return merged;
    endfunction

    logic [KEY_WORD_W:0]    storeWord;
    logic                   storeHalf;
    logic [KEY_W-1:0]       storedKey;
    logic [2:0]             chanSel;
    logic [KEY_W-1:0]       hardwareKey;
    logic                   storeOk;
    logic [KEY_WORD_W:0]    instrWord;
    logic [KEY_WORD_W-1:0]  mergedWord;
    logic [STATUS_W-1:0]    setBits;
    logic [STATUS_W-1:0]    clearBits;
    logic                   busRead;
    logic                   busWrite;
    logic [BUS_ADDR_W-1:0]  wordAddr;
    logic [DATA_W-1:0]      hwKeyView;
    logic [DATA_W-1:0]      clearMerge;
    logic [DATA_W-1:0]      enableMerge;

    // Store-path key lookup and comparison
    always_comb begin
        storeWord = s.keyMem[storeAddress[MEM_ADDR_W-1:BLOCK_SHIFT+1]];
        storeHalf = storeAddress[BLOCK_SHIFT];
        storedKey = storeHalf ? storeWord[3:0] : storeWord[7:4];
        if (selectorIndex > 3'h5) begin
            chanSel = 3'h6;
        end else begin
            chanSel = selectorIndex + 3'h1;
        end
        unique case (mode)
            MODE_NORMAL:   hardwareKey = s.normalKey;
            MODE_MUX:      hardwareKey = s.chanKey[0];
            MODE_SELECTOR: hardwareKey = s.chanKey[chanSel];
            default:       hardwareKey = s.normalKey;
        endcase
        storeOk = (storedKey == hardwareKey) || (storedKey == RESET_KEY) ||
                  (hardwareKey == RESET_KEY);
    end

    always_comb begin
        hwKeyView = {s.chanKey, s.normalKey};
        instrWord = s.keyMem[s.protectAddressReg];
        // Untouched half comes from the key memory word, new key from the data register
        if (s.halfSelectFlag) begin
            mergedWord = {instrWord[7:4], s.dataRegister[3:0]};
        end else begin
            mergedWord = {s.dataRegister[7:4], instrWord[3:0]};
        end
    end

    always_comb begin
        next_s    = s;
        setBits   = '0;
        clearBits = '0;
        busRead   = avsRead && !avsWrite;
        busWrite  = avsWrite && !avsRead;
        wordAddr  = {avsAddress[BUS_ADDR_W-1:2], 2'b00};
        clearMerge  = mergeBytes(RESET_WORD, avsWriteData, avsByteEnable);
        enableMerge = mergeBytes({16'h0000, s.intEnable}, avsWriteData, avsByteEnable);

        // Bus slave: one wait cycle, then the answer
        if ((busRead || busWrite) && s.waitReq) begin
            next_s.waitReq = 1'b0;
            next_s.readData = RESET_WORD;
            if (busRead) begin
                unique case (wordAddr)
                    OFS_STATUS:     next_s.readData = {16'h0000, s.status};
                    OFS_INT_ENABLE: next_s.readData = {16'h0000, s.intEnable};
                    OFS_COMMAND: begin
                        next_s.readData[0] = (s.seq != SEQ_IDLE);
                        next_s.readData[1] = s.halfSelectFlag;
                        next_s.readData[CMD_PA_LSB +: PROT_ADDR_W] = s.protectAddressReg;
                        next_s.readData[CMD_DR_LSB +: KEY_WORD_W] = s.dataRegister;
                        next_s.readData[CMD_CFF_LSB +: KEY_W] = s.conditionFlipFlops;
                    end
                    OFS_OP_ADDR:    next_s.readData = s.opAddr;
                    OFS_OP_KEY:     next_s.readData = s.opKey;
                    OFS_RESULT:     next_s.readData = s.result;
                    OFS_HW_KEYS:    next_s.readData = hwKeyView;
                    default: begin
                        for (int i = 0; i < PROGRAM_STATES; i++) begin
                            if (wordAddr == OFS_ISW0 + 8'(i * 4)) begin
                                next_s.readData = s.isw[i];
                            end
                        end
                    end
                endcase
            end
        end else begin
            next_s.waitReq = 1'b1;
        end

        if (busWrite && !s.waitReq) begin
            unique case (wordAddr)
                OFS_INT_CLEAR:  clearBits = clearMerge[STATUS_W-1:0];
                OFS_INT_ENABLE: next_s.intEnable = enableMerge[STATUS_W-1:0];
                OFS_COMMAND: begin
                    if (avsByteEnable[0] && s.seq == SEQ_IDLE) begin
                        if (avsWriteData[7:0] == SET_KEY_OPCODE ||
                            avsWriteData[7:0] == INSERT_KEY_OPCODE) begin
                            if (!privilegedState) begin
                                setBits[ST_PRIV_REFUSE] = 1'b1;
                            end else begin
                                next_s.protectAddressReg = s.opAddr[MEM_ADDR_W-1:BLOCK_SHIFT+1];
                                next_s.halfSelectFlag = s.opAddr[BLOCK_SHIFT];
                                next_s.seq = (avsWriteData[7:0] == SET_KEY_OPCODE) ?
                                             SEQ_SET_KEY_CHECK : SEQ_KEY_READ;
                            end
                        end
                    end
                end
                OFS_OP_ADDR:    next_s.opAddr = mergeBytes(s.opAddr, avsWriteData, avsByteEnable);
                OFS_OP_KEY:     next_s.opKey = mergeBytes(s.opKey, avsWriteData, avsByteEnable);
                default: begin
                    for (int i = 0; i < PROGRAM_STATES; i++) begin
                        if (wordAddr == OFS_ISW0 + 8'(i * 4)) begin
                            next_s.isw[i] = mergeBytes(s.isw[i], avsWriteData, avsByteEnable);
                        end
                    end
                end
            endcase
        end

        // Key instruction sequencer
        unique case (s.seq)
            SEQ_IDLE: begin
            end
            SEQ_SET_KEY_CHECK: begin
                if (s.opAddr[CHECK_BITS-1:0] != '0) begin
                    setBits[ST_ADDR_EXC] = 1'b1;
                    next_s.seq = SEQ_IDLE;
                end else begin
                    next_s.seq = SEQ_KEY_TRANSFER;
                end
            end
            SEQ_KEY_TRANSFER: begin
                next_s.dataRegister = {s.opKey[OP_KEY_LSB +: KEY_W], s.opKey[OP_KEY_LSB +: KEY_W]};
                next_s.seq = SEQ_KEY_MERGE_WRITE;
            end
            SEQ_KEY_MERGE_WRITE: begin
                // Odd parity over the eight key bits
                next_s.keyMem[s.protectAddressReg] = {~^mergedWord, mergedWord};
                next_s.dataRegister = mergedWord;
                setBits[ST_OP_DONE] = 1'b1;
                next_s.seq = SEQ_IDLE;
            end
            SEQ_KEY_READ: begin
                next_s.conditionFlipFlops = s.halfSelectFlag ? instrWord[3:0] : instrWord[7:4];
                next_s.seq = SEQ_INSERT_TRANSFER;
            end
            SEQ_INSERT_TRANSFER: begin
                next_s.result = RESET_WORD;
                next_s.result[DIGIT6_LSB +: KEY_W] = s.conditionFlipFlops;
                setBits[ST_OP_DONE] = 1'b1;
                next_s.seq = SEQ_IDLE;
            end
            default: begin
                next_s.seq = SEQ_IDLE;
            end
        endcase

        // Hardware key registers; a state entry outranks the console
        if (stateEnter) begin
            next_s.normalKey = s.isw[stateIndex][ISW_KEY_LSB +: KEY_W];
        end else if (consoleKeyLoad) begin
            next_s.normalKey = consoleKey;
        end
        if (channelKeyLoad && channelKeyIndex < 3'(CHAN_KEYS)) begin
            next_s.chanKey[channelKeyIndex] = channelKey;
        end

        // Store check outcome, one cycle after the request
        next_s.writeStrobe = storeRequest && storeOk;
        next_s.keyError = storeRequest && !storeOk;
        if (storeRequest) begin
            next_s.matchOk = storeOk;
        end
        if (storeRequest && !storeOk) begin
            setBits[ST_KEY_ERR] = 1'b1;
            if (mode == MODE_NORMAL) begin
                setBits[ST_ADDR_EXC] = 1'b1;
            end else begin
                setBits[ST_PROT_CHECK] = 1'b1;
            end
        end

        // Set wins over a simultaneous clear
        next_s.status = (s.status & ~clearBits) | setBits;
        next_s.irq = |(next_s.status & next_s.intEnable);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '{seq: SEQ_IDLE, waitReq: 1'b1, status: RESET_STATUS, intEnable: RESET_STATUS,
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign avsReadData          = s.readData;
    assign avsWaitRequest       = s.waitReq;
    assign memoryWriteStrobe    = s.writeStrobe;
    assign keyErrorSignal       = s.keyError;
    assign keyMatchOk           = s.matchOk;
    assign addressExceptionFlag = s.status[ST_ADDR_EXC];
    assign protectionCheckFlag  = s.status[ST_PROT_CHECK];
    assign interruptRequest     = s.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_MISMATCH_BLOCKS: assert property (
        storeRequest && !storeOk |=> !memoryWriteStrobe && keyErrorSignal && !keyMatchOk)
        else $error("Mismatching store was not blocked");

    AST_ZERO_KEY_PASSES: assert property (
        storeRequest && (storedKey == 4'h0 || hardwareKey == 4'h0) |=> memoryWriteStrobe && !keyErrorSignal)
        else $error("Zero key did not permit the store");

    AST_NO_STORE_NO_STROBE: assert property (
        !storeRequest |=> !memoryWriteStrobe && !keyErrorSignal)
        else $error("Strobe without a store request");

    AST_NORMAL_EXCEPTION: assert property (
        storeRequest && !storeOk && mode == MODE_NORMAL && !protectionCheckFlag
            |=> addressExceptionFlag && !protectionCheckFlag)
        else $error("Normal-mode mismatch did not raise address exception alone");

    AST_CHANNEL_PROTCHECK: assert property (
        storeRequest && !storeOk && mode != MODE_NORMAL && s.seq == SEQ_IDLE && !addressExceptionFlag
            |=> protectionCheckFlag && !addressExceptionFlag)
        else $error("Channel-mode mismatch handled wrongly");

    AST_STATE_KEY_LOAD: assert property (
        stateEnter |=> s.normalKey == $past(s.isw[stateIndex][ISW_KEY_LSB +: KEY_W]))
        else $error("State entry did not load its key");

    AST_CONSOLE_KEY_LOAD: assert property (
        consoleKeyLoad && !stateEnter |=> s.normalKey == $past(consoleKey))
        else $error("Console key load lost");

    AST_CHECK_ABORTS: assert property (
        s.seq == SEQ_SET_KEY_CHECK && s.opAddr[3:0] != 4'h0 |=> addressExceptionFlag && s.seq == SEQ_IDLE)
        else $error("Set-key address check did not abort");

    AST_SET_KEY_FLOW: assert property (
        s.seq == SEQ_KEY_TRANSFER |=> s.seq == SEQ_KEY_MERGE_WRITE
            && s.dataRegister[7:4] == s.dataRegister[3:0] ##1 s.seq == SEQ_IDLE)
        else $error("Set-key sequence out of order");

    AST_MERGE_WRITE: assert property (
        s.seq == SEQ_KEY_MERGE_WRITE |=> s.keyMem[$past(s.protectAddressReg)] == {~^$past(mergedWord),
            $past(mergedWord)})
        else $error("Merged key word not written back");

    AST_INSERT_RESULT: assert property (
        s.seq == SEQ_KEY_READ |=> s.seq == SEQ_INSERT_TRANSFER ##1
            s.result[7:4] == $past(s.conditionFlipFlops) && s.status[ST_OP_DONE])
        else $error("Insert-key result wrong");

    AST_PRIV_REFUSE: assert property (
        busWrite && !s.waitReq && wordAddr == OFS_COMMAND && avsByteEnable[0] && !privilegedState
            && s.seq == SEQ_IDLE && avsWriteData[7:0] == SET_KEY_OPCODE
            |=> s.status[ST_PRIV_REFUSE] && s.seq == SEQ_IDLE)
        else $error("Unprivileged key command was not refused");

    AST_INSERT_READ: assert property (
        s.seq == SEQ_KEY_READ |=> s.conditionFlipFlops ==
            $past(s.keyMem[s.protectAddressReg][(s.halfSelectFlag ? 0 : 4) +: 4]))
        else $error("Insert-key nibble not held in condition flops");

    AST_BUS_ANSWER: assert property (
        (avsRead ^ avsWrite) && avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest)
        else $error("Bus answer timing wrong");

endmodule

`default_nettype wire

// *** rtl/storage_key_pkg.sv ***
package storage_key_pkg;

    localparam int          DATA_W         = 32;
    localparam int          BUS_ADDR_W     = 8;
    localparam int          STATUS_W       = 16;
    localparam int          KEY_W          = 4;
    localparam int          KEY_WORD_W     = 8;
    localparam int          KEYMEM_WORDS   = 128;
    localparam int          PROT_ADDR_W    = 7;
    localparam int          MEM_ADDR_W     = 19;
    localparam int          BLOCK_SHIFT    = 11;
    localparam int          CHAN_KEYS      = 7;
    localparam int          PROGRAM_STATES = 4;

    // Register byte offsets
    localparam logic [7:0]  OFS_STATUS     = 8'h00;
    localparam logic [7:0]  OFS_INT_CLEAR  = 8'h04;
    localparam logic [7:0]  OFS_INT_ENABLE = 8'h08;
    localparam logic [7:0]  OFS_COMMAND    = 8'h0C;
    localparam logic [7:0]  OFS_OP_ADDR    = 8'h10;
    localparam logic [7:0]  OFS_OP_KEY     = 8'h14;
    localparam logic [7:0]  OFS_RESULT     = 8'h18;
    localparam logic [7:0]  OFS_ISW0       = 8'h1C;
    localparam logic [7:0]  OFS_HW_KEYS    = 8'h2C;

    // Status bit positions
    localparam int          ST_ADDR_EXC    = 0;
    localparam int          ST_KEY_ERR     = 1;
    localparam int          ST_OP_DONE     = 2;
    localparam int          ST_PRIV_REFUSE = 3;
    localparam int          ST_PROT_CHECK  = 11;

    // Field positions
    localparam int          ISW_KEY_LSB    = 24;
    localparam int          OP_KEY_LSB     = 4;
    localparam int          DIGIT6_LSB     = 4;
    localparam int          CHECK_BITS     = 4;
    localparam int          CMD_DR_LSB     = 16;
    localparam int          CMD_CFF_LSB    = 24;
    localparam int          CMD_PA_LSB     = 8;

    localparam logic [7:0]  SET_KEY_OPCODE    = 8'h08;
    localparam logic [7:0]  INSERT_KEY_OPCODE = 8'h09;

    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    localparam logic [15:0] RESET_STATUS   = 16'h0000;
    localparam logic [3:0]  RESET_KEY      = 4'h0;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_MUX,
        MODE_SELECTOR
    } mode_t;

endpackage

// *** test/store_path_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module store_path_model (
    input  wire logic                                   clk,
    input  wire logic                                   memoryWriteStrobe,
    input  wire logic                                   keyErrorSignal,
    output logic                                        storeRequest,
    output logic [storage_key_pkg::MEM_ADDR_W-1:0]      storeAddress
);
    import storage_key_pkg::*;
    int writesSeen;
    initial begin
        storeRequest = 1'b0;
        storeAddress = 19'h0_0000;
        writesSeen = 0;
    end
    // One-cycle store pulse; released address shows the inverse
    task automatic store(input logic [MEM_ADDR_W-1:0] addr, output logic wr, output logic err);
        @(posedge clk);
        storeRequest <= 1'b1;
        storeAddress <= addr;
        @(posedge clk);
        storeRequest <= 1'b0;
        storeAddress <= ~addr;
        @(negedge clk);
        wr = memoryWriteStrobe;
        err = keyErrorSignal;
    endtask
    always @(negedge clk) begin
        if (memoryWriteStrobe === 1'b1)
            writesSeen <= writesSeen + 1;
    end
endmodule
`default_nettype wire

// *** test/storage_key_protection_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module storage_key_protection_test;
    import storage_key_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest;
    logic [7:0]  avsAddress = 8'h00;
    logic [31:0] avsWriteData = 32'h0000_0000, avsReadData, q;
    logic        privilegedState = 1'b1, stateEnter = 1'b0, consoleKeyLoad = 1'b0, channelKeyLoad = 1'b0;
    logic [1:0]  stateIndex = 2'h0;
    logic [2:0]  selectorIndex = 3'h0, channelKeyIndex = 3'h0;
    logic [3:0]  consoleKey = 4'h0, channelKey = 4'h0, k, hk, keyMem [256];
    mode_t       mode = MODE_NORMAL;
    logic        storeRequest, memoryWriteStrobe, keyErrorSignal, keyMatchOk, wr, err, ex;
    logic        addressExceptionFlag, protectionCheckFlag, interruptRequest;
    logic [18:0] storeAddress;
    logic [7:0]  b;
    int          num_errors = 0, checks_done = 0, seed = 32'h6b9a2bdb, s, expWrites = 0;
    always #10 clk = ~clk;
    storage_key_protection dut (.clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsByteEnable(4'hF), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .storeRequest(storeRequest), .storeAddress(storeAddress),
        .mode(mode), .selectorIndex(selectorIndex), .privilegedState(privilegedState),
        .stateEnter(stateEnter), .stateIndex(stateIndex), .consoleKeyLoad(consoleKeyLoad),
        .consoleKey(consoleKey), .channelKeyLoad(channelKeyLoad), .channelKeyIndex(channelKeyIndex),
        .channelKey(channelKey), .memoryWriteStrobe(memoryWriteStrobe), .keyErrorSignal(keyErrorSignal),
        .keyMatchOk(keyMatchOk), .addressExceptionFlag(addressExceptionFlag),
        .protectionCheckFlag(protectionCheckFlag), .interruptRequest(interruptRequest));
    store_path_model core (.clk(clk), .memoryWriteStrobe(memoryWriteStrobe), .keyErrorSignal(keyErrorSignal),
        .storeRequest(storeRequest), .storeAddress(storeAddress));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t word got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t bit got %b want %b", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        avsRead <= ~w;
        avsWrite <= w;
        avsAddress <= a;
        avsWriteData <= d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        r = avsReadData;
        @(posedge clk);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        avsWriteData <= ~d;
        if (n >= 50) begin
            $display("MISMATCH %0t bus answer missing", $time);
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic command(input logic [7:0] op, input logic [7:0] blk, input logic [3:0] key, input logic [3:0] lo);
        int n;
        bus(1'b1, OFS_INT_CLEAR, 32'hFFFF_FFFF, q);
        bus(1'b1, OFS_OP_ADDR, (32'(blk) << BLOCK_SHIFT) | 32'(lo), q);
        bus(1'b1, OFS_OP_KEY, 32'(key) << OP_KEY_LSB, q);
        bus(1'b1, OFS_COMMAND, 32'(op), q);
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
            n++;
        end while (q[ST_OP_DONE] !== 1'b1 && q[ST_ADDR_EXC] !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("MISMATCH %0t command never finished", $time);
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        stateEnter <= (which == 0);
        consoleKeyLoad <= (which == 1);
        channelKeyLoad <= (which == 2);
        @(posedge clk);
        stateEnter <= 1'b0;
        consoleKeyLoad <= 1'b0;
        channelKeyLoad <= 1'b0;
    endtask
    initial begin
        foreach (keyMem[i]) keyMem[i] = 4'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check32(q, 32'h0000_0000);
        bus(1'b0, OFS_HW_KEYS, 32'h0000_0000, q);
        check32(q, 32'h0000_0000);
        bus(1'b0, 8'h30, 32'h0000_0000, q);
        check32(q, 32'h0000_0000);
        privilegedState <= 1'b0;
        bus(1'b1, OFS_COMMAND, 32'(SET_KEY_OPCODE), q);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check1(q[ST_PRIV_REFUSE], 1'b1);
        privilegedState <= 1'b1;
        command(SET_KEY_OPCODE, 8'h05, 4'h9, 4'h3);
        check1(q[ST_ADDR_EXC], 1'b1);
        check1(addressExceptionFlag, 1'b1);
        $display("test basics done");
        bus(1'b1, OFS_INT_ENABLE, 32'h0000_0002, q);
        for (int i = 0; i < 6; i++) begin
            b = 8'($random(seed));
            k = (i == 0) ? 4'h0 : 4'($random(seed));
            command(SET_KEY_OPCODE, b, k, 4'h0);
            check1(q[ST_ADDR_EXC], 1'b0);
            keyMem[b] = k;
            for (int j = 0; j < 2; j++) begin
                command(INSERT_KEY_OPCODE, b ^ 8'(j), 4'h0, 4'h0);
                bus(1'b0, OFS_RESULT, 32'h0000_0000, q);
                check32(q, 32'(keyMem[b ^ 8'(j)]) << DIGIT6_LSB);
            end
            for (int m = 0; m < 3; m++) begin
                hk = (m == 0 && i == 1) ? k : 4'($random(seed));
                s = $unsigned($random(seed)) % 6;
                mode <= mode_t'(m);
                selectorIndex <= 3'(s);
                if (m == 0 && i[0] == 1'b0) begin
                    stateIndex <= 2'(i);
                    bus(1'b1, OFS_ISW0 + 8'(4 * (i % 4)), 32'(hk) << ISW_KEY_LSB, q);
                    pulse(0);
                end else if (m == 0) begin
                    consoleKey <= hk;
                    pulse(1);
                end else begin
                    channelKey <= hk;
                    channelKeyIndex <= (m == 1) ? 3'h0 : 3'(s + 1);
                    pulse(2);
                end
                bus(1'b0, OFS_HW_KEYS, 32'h0000_0000, q);
                check32(32'(q[m == 0 ? 0 : (m == 1 ? 4 : 8 + 4 * s) +: 4]), 32'(hk));
                bus(1'b1, OFS_INT_CLEAR, 32'hFFFF_FFFF, q);
                ex = (hk == k) || (hk == 4'h0) || (k == 4'h0);
                core.store({b, 11'($random(seed))}, wr, err);
                check1(wr, ex);
                check1(err, ~ex);
                check1(keyMatchOk, ex);
                if (ex) expWrites++;
                check1(addressExceptionFlag, ~ex && m == 0);
                check1(protectionCheckFlag, ~ex && m != 0);
                bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
                check1(q[ST_KEY_ERR], ~ex);
                check1(interruptRequest, ~ex);
            end
            $display("test round %0d done", i);
        end
        bus(1'b1, OFS_INT_ENABLE, 32'h0000_0000, q);
        bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        check1(interruptRequest, 1'b0);
        check32(32'(core.writesSeen), 32'(expWrites));
        $display("test masking done");
        end_of_test();
    end
endmodule
`default_nettype wire
